// >>> tag_frame_decoder.sv
// Purpose: Checks request frames, decodes request flags, decides on a reply, frames the reply.
// Assumes: Byte streams from and to the bit coder; registers over AXI4-Lite.
// Notes: Command execution and anticollision live outside this block.
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tag_frame_decoder #(
    parameter int MAX_REQ_BYTES = 32
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic rx_bit_clk,
    input wire tag_frame_pkg::byte_beat_t rx_beat,
    input wire logic rx_sof,
    input wire logic rx_eof,
    input wire logic rx_bit_error,
    output tag_frame_pkg::reply_mode_t req_mode,
    output logic req_accept,
    output logic req_reject,
    output logic [7:0] req_byte,
    output logic req_byte_valid,
    input wire logic [7:0] reply_data,
    input wire logic reply_valid,
    input wire logic reply_last,
    output logic reply_ready,
    output tag_frame_pkg::byte_beat_t tx_beat,
    output logic tx_start,
    input wire logic tx_ready,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import tag_frame_pkg::*;

    if (MAX_REQ_BYTES < 12 || MAX_REQ_BYTES > 255) begin : g_bad_max_req_bytes
        $error("MAX_REQ_BYTES out of range");
    end

    function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : strb_merge

    // Pin inputs pass two flip-flops; only the link clock is edge-detected, the frame strobes are sampled as synced levels.
    logic [1:0] clk_s1, clk_s2;
    logic [1:0] sof_s1, sof_s2;
    logic [1:0] eof_s1, eof_s2;
    logic [1:0] err_s1, err_s2;
    logic [9:0] beat_s1, beat_s2;
    logic clk_prev_r;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            clk_s1 <= '0;
            sof_s1 <= '0;
            eof_s1 <= '0;
            err_s1 <= '0;
            beat_s1 <= '0;
            clk_prev_r <= 1'b0;
        end else begin
            clk_s1 <= {clk_s1[0], rx_bit_clk};
            sof_s1 <= {sof_s1[0], rx_sof};
            eof_s1 <= {eof_s1[0], rx_eof};
            err_s1 <= {err_s1[0], rx_bit_error};
            beat_s1 <= {rx_beat.valid, rx_beat.data, rx_beat.last};
            clk_prev_r <= clk_s2[1];
        end
    end
    assign clk_s2 = clk_s1;
    assign sof_s2 = sof_s1;
    assign eof_s2 = eof_s1;
    assign err_s2 = err_s1;
    logic [9:0] beat_sync_r;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            beat_sync_r <= '0;
        end else begin
            beat_sync_r <= beat_s1;
        end
    end
    assign beat_s2 = beat_sync_r;

    // Inputs are sampled on the rising edge of the synchronised link clock.
    logic link_edge;
    assign link_edge = clk_s2[1] && !clk_prev_r;

    logic [31:0] ctrl_r;
    logic [63:0] uid_r;
    logic [15:0] crc_r;
    logic [15:0] crc_step;
    logic [7:0] flags_r;
    logic [7:0] cmd_r;
    logic [7:0] count_r;
    logic uid_match_r;
    logic in_frame_r;
    logic frame_bad_r;
    logic [7:0] last_flags_r;
    logic [2:0] last_verdict_r;
    logic [15:0] good_cnt_r;
    logic [15:0] drop_cnt_r;

    logic [7:0] rx_byte;
    assign rx_byte = beat_s2[8:1];

    crc16_byte u_rx_crc (
        .crc_in(crc_r),
        .data(rx_byte),
        .crc_out(crc_step)
    );

    // Flag legality: reserved, extension or select bits all silence the tag.
    function automatic logic flags_illegal(input logic [7:0] f);
        return f[FLAG_RESERVED]
            || f[FLAG_EXTENSION]
            || f[FLAG_SELECT];
    endfunction : flags_illegal

    // Identifier sits after flags and command only in addressed, non-inventory requests.
    function automatic logic uid_present(input logic [7:0] f);
        return f[FLAG_ADDRESS] && !f[FLAG_INVENTORY];
    endfunction : uid_present

    logic byte_in;
    assign byte_in = link_edge && beat_s2[9] && in_frame_r;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            in_frame_r <= 1'b0;
            crc_r <= CRC_PRESET;
            count_r <= '0;
            flags_r <= '0;
            cmd_r <= '0;
            uid_match_r <= 1'b1;
            frame_bad_r <= 1'b0;
        end else if (link_edge && sof_s2[1]) begin
            in_frame_r <= 1'b1;
            crc_r <= CRC_PRESET;
            count_r <= '0;
            uid_match_r <= 1'b1;
            frame_bad_r <= 1'b0;
        end else if (link_edge && (err_s2[1] || (eof_s2[1] && in_frame_r))) begin
            in_frame_r <= 1'b0;
        end else if (byte_in) begin
            crc_r <= crc_step;
            if (count_r == 8'(MAX_REQ_BYTES)) begin
                frame_bad_r <= 1'b1;
            end else begin
                count_r <= count_r + 8'h01;
            end
            if (count_r == 8'h00) begin
                flags_r <= rx_byte;
            end
            if (count_r == 8'(CMD_POS)) begin
                cmd_r <= rx_byte;
            end
            // Identifier arrives low byte first.
            if (uid_present(flags_r) && count_r >= 8'(UID_POS)
                    && count_r < 8'(UID_POS + UID_BYTES)) begin
                if (rx_byte != uid_r[(count_r - 8'(UID_POS)) * 8 +: 8]) begin
                    uid_match_r <= 1'b0;
                end
            end
        end
    end

    // End of request: verdict decides whether anything may be sent.
    logic eof_now;
    assign eof_now = link_edge && eof_s2[1] && in_frame_r;
    logic crc_ok, len_ok, addr_ok, verdict_ok;
    assign crc_ok = (crc_r == CRC_RESIDUE);
    assign len_ok = !frame_bad_r && !err_s2[1] && count_r >= 8'(CMD_POS + 3);
    assign addr_ok = !uid_present(flags_r) || (uid_match_r
                     && count_r >= 8'(UID_POS + UID_BYTES + 2));
    assign verdict_ok = crc_ok && len_ok && addr_ok && !flags_illegal(flags_r);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            req_accept <= 1'b0;
            req_reject <= 1'b0;
            req_mode <= '0;
            last_flags_r <= '0;
            last_verdict_r <= '0;
            good_cnt_r <= '0;
            drop_cnt_r <= '0;
        end else begin
            req_accept <= eof_now && verdict_ok && !ctrl_r[0];
            req_reject <= eof_now && !(verdict_ok && !ctrl_r[0]);
            if (eof_now) begin
                last_flags_r <= flags_r;
                last_verdict_r <= {!crc_ok, !len_ok, !addr_ok};
                if (verdict_ok && !ctrl_r[0]) begin
                    good_cnt_r <= good_cnt_r + 16'h0001;
                    req_mode.two_subcarriers <= flags_r[FLAG_SUBCARRIER];
                    req_mode.high_rate <= flags_r[FLAG_RATE];
                    req_mode.inventory <= flags_r[FLAG_INVENTORY];
                    req_mode.single_slot <= flags_r[FLAG_INVENTORY] && flags_r[FLAG_ADDRESS];
                    req_mode.option <= flags_r[FLAG_OPTION];
                    req_mode.command <= cmd_r;
                end else begin
                    drop_cnt_r <= drop_cnt_r + 16'h0001;
                end
            end
        end
    end

    // Request bytes are passed on only after the frame is accepted is not possible without a
    // buffer, so each byte is forwarded live and consumers act on req_accept alone.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            req_byte <= '0;
            req_byte_valid <= 1'b0;
        end else begin
            req_byte_valid <= byte_in;
            if (byte_in) begin
                req_byte <= rx_byte;
            end
        end
    end

    // Reply framer: flags, caller bytes, inverted checksum low byte first.
    typedef enum {TX_IDLE, TX_FLAGS, TX_BODY, TX_CRC_LO, TX_CRC_HI} tx_state_t;
    tx_state_t tx_state_r;
    logic [15:0] tx_crc_r;
    logic [15:0] tx_crc_step;
    logic [7:0] tx_next_byte;
    logic armed_r;

    always_comb begin
        case (tx_state_r)
            TX_FLAGS: tx_next_byte = RESP_FLAGS_OK;
            TX_BODY: tx_next_byte = reply_data;
            default: tx_next_byte = 8'h00;
        endcase
    end

    crc16_byte u_tx_crc (
        .crc_in(tx_crc_r),
        .data(tx_next_byte),
        .crc_out(tx_crc_step)
    );

    logic tx_take;
    assign tx_take = tx_ready && !(tx_beat.valid);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            tx_state_r <= TX_IDLE;
            tx_crc_r <= CRC_PRESET;
            tx_beat <= '0;
            tx_start <= 1'b0;
            reply_ready <= 1'b0;
            armed_r <= 1'b0;
        end else begin
            tx_start <= 1'b0;
            reply_ready <= 1'b0;
            if (tx_beat.valid && tx_ready) begin
                tx_beat.valid <= 1'b0;
            end
            if (req_accept) begin
                armed_r <= 1'b1;
            end
            case (tx_state_r)
                TX_IDLE: begin
                    if (armed_r && reply_valid) begin
                        armed_r <= req_accept;
                        tx_state_r <= TX_FLAGS;
                        tx_crc_r <= CRC_PRESET;
                        tx_start <= 1'b1;
                    end
                end
                TX_FLAGS: begin
                    if (tx_take) begin
                        tx_beat <= '{valid: 1'b1, data: tx_next_byte, last: 1'b0};
                        tx_crc_r <= tx_crc_step;
                        tx_state_r <= TX_BODY;
                    end
                end
                TX_BODY: begin
                    if (tx_take && reply_valid && !reply_ready) begin
                        tx_beat <= '{valid: 1'b1, data: tx_next_byte, last: 1'b0};
                        tx_crc_r <= tx_crc_step;
                        reply_ready <= 1'b1;
                        if (reply_last) begin
                            tx_state_r <= TX_CRC_LO;
                        end
                    end
                end
                TX_CRC_LO: begin
                    if (tx_take) begin
                        tx_beat <= '{valid: 1'b1, data: ~tx_crc_r[7:0], last: 1'b0};
                        tx_state_r <= TX_CRC_HI;
                    end
                end
                TX_CRC_HI: begin
                    if (tx_take) begin
                        tx_beat <= '{valid: 1'b1, data: ~tx_crc_r[15:8], last: 1'b1};
                        tx_state_r <= TX_IDLE;
                    end
                end
                default: tx_state_r <= TX_IDLE;
            endcase
        end
    end

    // AXI4-Lite slave: address and data taken in either order, response one cycle later.
    logic aw_held_r, w_held_r;
    logic [5:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= '0;
            w_strb_r <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            ctrl_r <= CTRL_RESET;
            uid_r <= UID_RESET;
        end else begin
            s_axi_awready <= !aw_held_r && !s_axi_awready && !s_axi_bvalid && s_axi_awvalid;
            s_axi_wready <= !w_held_r && !s_axi_wready && !s_axi_bvalid && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (aw_held_r && w_held_r && !s_axi_bvalid) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= RESP_OKAY;
                case ({aw_addr_r[5:2], 2'b00})
                    REG_CTRL: ctrl_r <= strb_merge(ctrl_r, w_data_r, w_strb_r);
                    REG_UID_LO: uid_r[31:0] <= strb_merge(uid_r[31:0], w_data_r, w_strb_r);
                    REG_UID_HI: uid_r[63:32] <= strb_merge(uid_r[63:32], w_data_r, w_strb_r);
                    REG_STATUS, REG_LAST, REG_COUNT: ;
                    default: s_axi_bresp <= RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OKAY;
                case ({s_axi_araddr[5:2], 2'b00})
                    REG_CTRL: s_axi_rdata <= ctrl_r;
                    REG_STATUS: s_axi_rdata <= {26'h0, armed_r, in_frame_r,
                                                tx_state_r != TX_IDLE, last_verdict_r};
                    REG_UID_LO: s_axi_rdata <= uid_r[31:0];
                    REG_UID_HI: s_axi_rdata <= uid_r[63:32];
                    REG_LAST: s_axi_rdata <= {16'h0, cmd_r, last_flags_r};
                    REG_COUNT: s_axi_rdata <= {drop_cnt_r, good_cnt_r};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : tag_frame_decoder
`default_nettype wire

// >>> tag_frame_pkg.sv
// Purpose: Shared constants and carrier types for the tag frame and flag decoder.
// Assumes: 32-bit AXI4-Lite register bus, byte-wide frame streams.
// Notes: Register offsets are byte addresses of aligned words.
package tag_frame_pkg;
    localparam logic [15:0] CRC_PRESET = 16'hFFFF;
    localparam logic [15:0] CRC_POLY_REFL = 16'h8408;
    localparam logic [15:0] CRC_RESIDUE = 16'hF0B8;
    localparam int FLAG_SUBCARRIER = 0;
    localparam int FLAG_RATE = 1;
    localparam int FLAG_INVENTORY = 2;
    localparam int FLAG_EXTENSION = 3;
    localparam int FLAG_SELECT = 4;
    localparam int FLAG_ADDRESS = 5;
    localparam int FLAG_OPTION = 6;
    localparam int FLAG_RESERVED = 7;
    localparam int UID_BYTES = 8;
    localparam int CMD_POS = 1;
    localparam int UID_POS = 2;
    localparam logic [7:0] RESP_FLAGS_OK = 8'h00;
    localparam logic [5:0] REG_CTRL = 6'h00;
    localparam logic [5:0] REG_STATUS = 6'h04;
    localparam logic [5:0] REG_UID_LO = 6'h08;
    localparam logic [5:0] REG_UID_HI = 6'h0C;
    localparam logic [5:0] REG_LAST = 6'h10;
    localparam logic [5:0] REG_COUNT = 6'h14;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [63:0] UID_RESET = 64'h0123_4567_89AB_CDEF;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic last;
    } byte_beat_t;

    typedef struct packed {
        logic two_subcarriers;
        logic high_rate;
        logic inventory;
        logic single_slot;
        logic option;
        logic [7:0] command;
    } reply_mode_t;
endpackage : tag_frame_pkg

// >>> crc16_byte.sv
// Purpose: One-byte step of the reflected 16-bit frame checksum.
// Assumes: Bytes enter lowest-order bit first.
// Notes: Combinational; the caller keeps the register.
`timescale 1ns/1ps
`default_nettype none
module crc16_byte (
    input wire logic [15:0] crc_in,
    input wire logic [7:0] data,
    output logic [15:0] crc_out
);
    import tag_frame_pkg::*;

    always_comb begin
        logic [15:0] c;
        c = crc_in ^ {8'h00, data};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
        end
        crc_out = c;
    end
endmodule : crc16_byte
`default_nettype wire

// >>> tag_frame_decoder_assertions.sv
// Purpose: Port-level protocol checks for the tag frame decoder.
// Assumes: One clock domain with synchronous active-low reset.
// Notes: Bound to every decoder instance.
`timescale 1ns/1ps
`default_nettype none
module tag_frame_decoder_assertions (
    input wire logic clk,
    input wire logic nrst,
    input wire tag_frame_pkg::reply_mode_t req_mode,
    input wire logic req_accept,
    input wire logic req_reject,
    input wire logic reply_ready,
    input wire tag_frame_pkg::byte_beat_t tx_beat,
    input wire logic tx_start,
    input wire logic tx_ready
);
    import tag_frame_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic first_r;
    logic armed_r;
    logic [7:0] cnt_r;
    always_ff @(posedge clk) begin
        if (!nrst || (tx_beat.valid && tx_ready)) first_r <= 1'h0;
        else if (tx_start) first_r <= 1'h1;
    end
    always_ff @(posedge clk) begin
        if (!nrst || tx_start) armed_r <= 1'h0;
        else if (req_accept) armed_r <= 1'h1;
    end
    always_ff @(posedge clk) begin
        if (!nrst || tx_start) cnt_r <= 8'h00;
        else if (tx_beat.valid && tx_ready) cnt_r <= cnt_r + 8'h01;
    end
    a_verdict_once: assert property ((req_accept || req_reject) |=>
        !(req_accept || req_reject)) else $error("verdict pulse too long");
    a_verdict_excl: assert property (!(req_accept && req_reject))
        else $error("accept and drop together");
    a_start_armed: assert property (tx_start |-> armed_r)
        else $error("reply started without accepted request");
    a_flags_zero: assert property (first_r && tx_beat.valid |->
        tx_beat.data == RESP_FLAGS_OK) else $error("reply flags not zero");
    a_beat_hold: assert property (tx_beat.valid && !tx_ready |=>
        tx_beat.valid && $stable(tx_beat)) else $error("beat changed before taken");
    a_crc_tail: assert property (tx_beat.valid && tx_ready && tx_beat.last |->
        cnt_r >= 8'h02) else $error("reply too short for flags and checksum");
    a_mode_kept: assert property (!req_accept |-> $stable(req_mode))
        else $error("reply mode changed without accept");
    a_ready_pulse: assert property (reply_ready |=> !reply_ready)
        else $error("body ready longer than one cycle");
endmodule : tag_frame_decoder_assertions
bind tag_frame_decoder tag_frame_decoder_assertions i_tag_frame_decoder_assertions (
    .clk, .nrst, .req_mode, .req_accept, .req_reject, .reply_ready, .tx_beat, .tx_start,
    .tx_ready);
`default_nettype wire

// >>> reader_model.sv
// Purpose: Reader side of the link: sends request frames, takes reply bytes.
// Assumes: Link clock runs only within frames.
// Notes: Set slow to stall the reply path every other cycle.
`timescale 1ns/1ps
`default_nettype none
module reader_model (
    input wire logic clk,
    input wire tag_frame_pkg::byte_beat_t tx_beat,
    output logic rx_bit_clk,
    output tag_frame_pkg::byte_beat_t rx_beat,
    output logic rx_sof,
    output logic rx_eof,
    output logic rx_bit_error,
    output logic tx_ready
);
    import tag_frame_pkg::*;
    logic slow;
    logic [7:0] got[$];
    initial begin
        slow = 1'h0;
        rx_bit_clk = 1'h0;
        rx_beat = '0;
        rx_sof = 1'h0;
        rx_eof = 1'h0;
        rx_bit_error = 1'h0;
        tx_ready = 1'h0;
    end
    always @(posedge clk) begin
        tx_ready <= slow ? !tx_ready : 1'h1;
        if (tx_beat.valid && tx_ready) got.push_back(tx_beat.data);
    end
    task automatic tick();
        #62.5 rx_bit_clk = 1'h1;
        #62.5 rx_bit_clk = 1'h0;
    endtask : tick
    task automatic send(input logic [7:0] f[$], input logic err);
        #1 rx_sof = 1'h1;
        tick();
        rx_sof = 1'h0;
        foreach (f[i]) begin
            rx_beat = '{1'h1, f[i], i == f.size() - 1};
            tick();
        end
        // Released data lines show no stale byte.
        rx_beat = '{1'h0, ~rx_beat.data, 1'h0};
        rx_bit_error = err;
        rx_eof = 1'h1;
        tick();
        rx_eof = 1'h0;
        rx_bit_error = 1'h0;
        rx_beat.data = ~rx_beat.data;
    endtask : send
endmodule : reader_model
`default_nettype wire

// >>> tag_frame_decoder_test.sv
// Purpose: Self-checking bench for the tag frame decoder.
// Assumes: Reader model on the link, bench as register bus master.
// Notes: Every accepted request gets a one-byte reply body.
`timescale 1ns/1ps
`default_nettype none
module tag_frame_decoder_test;
    import tag_frame_pkg::*;
    logic clk = 1'h0, nrst = 1'h0, rx_bit_clk, rx_sof, rx_eof, rx_bit_error, tx_start;
    logic tx_ready, req_accept, req_reject, req_byte_valid, reply_ready;
    byte_beat_t rx_beat, tx_beat;
    reply_mode_t req_mode;
    logic [7:0] req_byte, reply_data = 8'h00;
    logic reply_valid = 1'h0, reply_last = 1'h1;
    logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int error_cnt = 0, checks = 0, cyc = 0, acc_n = 0, rej_n = 0, st_n = 0, byt_n = 0;
    tag_frame_decoder #(.MAX_REQ_BYTES(32)) i_tag_frame_decoder (.clk, .nrst, .rx_bit_clk,
        .rx_beat, .rx_sof, .rx_eof, .rx_bit_error, .req_mode, .req_accept, .req_reject,
        .req_byte, .req_byte_valid, .reply_data, .reply_valid, .reply_last, .reply_ready,
        .tx_beat, .tx_start, .tx_ready, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    reader_model i_reader_model (.clk, .tx_beat, .rx_bit_clk, .rx_beat, .rx_sof, .rx_eof,
        .rx_bit_error, .tx_ready);
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        acc_n <= acc_n + req_accept;
        rej_n <= rej_n + req_reject;
        st_n <= st_n + tx_start;
        byt_n <= byt_n + req_byte_valid;
        if (cyc == 20000) begin
            error_cnt = error_cnt + 1;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic axw(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        s_axi_bready <= 1'h1;
        do @(posedge clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        chk(s_axi_bresp, r);
    endtask : axw
    task automatic axr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        s_axi_rready <= 1'h1;
        do @(posedge clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        chk(s_axi_rdata, d);
        chk(s_axi_rresp, r);
    endtask : axr
    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c;
        c = CRC_PRESET;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY_REFL : c >> 1;
        end
        return c;
    endfunction : crc16
    task automatic reply(input logic [7:0] b);
        logic [15:0] c;
        c = ~crc16({RESP_FLAGS_OK, b});
        i_reader_model.got.delete();
        reply_data <= b;
        reply_valid <= 1'h1;
        do @(posedge clk); while (!reply_ready);
        reply_valid <= 1'h0;
        for (int i = 0; i < 500 && i_reader_model.got.size() < 4; i++) @(posedge clk);
        chk(i_reader_model.got.size(), 4);
        chk(i_reader_model.got[0], RESP_FLAGS_OK);
        chk(i_reader_model.got[1], b);
        chk({i_reader_model.got[3], i_reader_model.got[2]}, c);
    endtask : reply
    task automatic frame(input logic [7:0] fl, input logic [63:0] uid, input logic bad,
                         input logic err, input int ok);
        logic [7:0] q[$];
        logic [15:0] c;
        int a, r, s, b;
        q = {fl, 8'h2B};
        if (fl[FLAG_ADDRESS] && !fl[FLAG_INVENTORY])
            for (int i = 0; i < UID_BYTES; i++) q.push_back(uid[8*i +: 8]);
        c = ~crc16(q) ^ {15'h0000, bad};
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        a = acc_n;
        r = rej_n;
        s = st_n;
        b = byt_n;
        // A dropped request is offered a reply body, which must stay unused.
        reply_valid <= (ok == 0);
        i_reader_model.send(q, err);
        for (int i = 0; i < 30 && acc_n + rej_n == a + r; i++) @(posedge clk);
        repeat (10) @(posedge clk);
        chk(acc_n - a, ok);
        chk(rej_n - r, 1 - ok);
        chk(st_n - s, 0);
        chk(byt_n - b, q.size());
        reply_valid <= 1'h0;
        if (ok == 1) reply(fl ^ 8'hA5);
    endtask : frame
    task automatic t_regs();
        axr(REG_CTRL, CTRL_RESET, RESP_OKAY);
        axr(REG_UID_HI, UID_RESET[63:32], RESP_OKAY);
        axw(REG_CTRL, 32'h1, RESP_OKAY);
        frame(8'h02, '0, 1'h0, 1'h0, 0);
        axw(REG_CTRL, 32'h0, RESP_OKAY);
        axw(REG_UID_LO, 32'h1357_9BDF, RESP_OKAY);
        axr(REG_UID_LO, 32'h1357_9BDF, RESP_OKAY);
        frame(8'h20, {UID_RESET[63:32], 32'h1357_9BDF}, 1'h0, 1'h0, 1);
        axr(REG_COUNT, 32'h0001_0001, RESP_OKAY);
        axw(REG_UID_LO, UID_RESET[31:0], RESP_OKAY);
        axw(6'h3C, 32'h0, RESP_SLVERR);
        axr(6'h3C, 32'h0, RESP_SLVERR);
        $display("test registers done");
    endtask : t_regs
    task automatic t_plain();
        frame(8'h03, '0, 1'h0, 1'h0, 1);
        chk(req_mode.two_subcarriers, 1'h1);
        chk(req_mode.high_rate, 1'h1);
        chk(req_mode.command, 8'h2B);
        frame(8'h03, '0, 1'h1, 1'h0, 0);
        frame(8'h03, '0, 1'h0, 1'h1, 0);
        $display("test plain done");
    endtask : t_plain
    task automatic t_flags();
        logic [7:0] bad[4] = '{8'h08, 8'h10, 8'h14, 8'h80};
        foreach (bad[i]) frame(bad[i], '0, 1'h0, 1'h0, 0);
        frame(8'h66, '0, 1'h0, 1'h0, 1);
        chk(req_mode.inventory, 1'h1);
        chk(req_mode.single_slot, 1'h1);
        chk(req_mode.option, 1'h1);
        frame(8'h04, '0, 1'h0, 1'h0, 1);
        chk(req_mode.single_slot, 1'h0);
        chk(req_mode.high_rate, 1'h0);
        $display("test flags done");
    endtask : t_flags
    task automatic t_addr();
        i_reader_model.slow = 1'h1;
        frame(8'h21, UID_RESET, 1'h0, 1'h0, 1);
        i_reader_model.slow = 1'h0;
        frame(8'h20, UID_RESET ^ 64'h1, 1'h0, 1'h0, 0);
        frame(8'h20, UID_RESET ^ 64'h8000_0000_0000_0000, 1'h0, 1'h0, 0);
        $display("test addressed done");
    endtask : t_addr
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'h1;
        repeat (3) @(posedge clk);
        t_regs();
        t_plain();
        t_flags();
        t_addr();
        end_sim();
    end
endmodule : tag_frame_decoder_test
`default_nettype wire
